/* logic/pmsc_top.sv */
// Operation
// - power request low forces off, defaults
// - off state drives system reset low
// - enter wait on request, enable clear
// - faults enter standby, resolved returns wait
// - mirror bit only enables mirror supplies
// - both bits enable mirror and LED
// - mirror bit cleared on request rise, fault
// - enable bits live at address 0x01
// - speed select field at address 0x17
// - select high ignores input, output floats
// - sample rising edge, shift falling edge
// - command MSB one writes, zero reads
// - low seven bits give start address
// - address increments after each data byte
// - address wraps 0x7F to 0x00
// - faults set flags, pull interrupt low
// - set mask bit blocks its interrupt
// - high-level flags OR low-level faults
// - supply and illumination fault grouping
`timescale 1ns/1ns
`default_nettype none
`include "pmsc_params.svh"

module pmsc_top #(
   parameter int SYNC_STAGES = 2
) (
   // core clock and control
   input  wire logic                  I_CORE_CLK,
   input  wire logic                  I_RESET,
   input  wire logic                  I_CLK_EN,
   // power request and monitors
   input  wire logic                  I_POWER_REQUEST,
   input  wire pmsc_pkg::pmsc_faults_t I_FAULTS,
   // serial port
   input  wire logic                  I_SPI_CLK,
   input  wire logic                  I_SPI_SS_N,
   input  wire logic                  I_SPI_MOSI,
   output logic                       O_SPI_MISO,
   output logic                       O_SPI_MISO_OE,
   // system outputs
   output logic                       O_SYS_RESET_N,
   output logic                       O_INT_N,
   output logic                       O_MIRROR_SUPPLY_EN,
   output logic                       O_LED_POWER_EN,
   output logic                       O_SERIAL_SPEED_SEL
);

   if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
   end

   localparam int PW = $bits(pmsc_pkg::pmsc_faults_t) + 1;

   // core domain
   logic [SYNC_STAGES-1:0][PW-1:0] pin_sync_reg;
   logic [SYNC_STAGES-1:0]         req_sync_reg;
   logic                           req_seen_reg;
   logic                           ack_reg;
   logic                           off_reg;
   logic                           pr_prev_reg;
   logic                           cmd_write_reg;
   logic [6:0]                     rd_ptr_reg;
   logic [6:0]                     wr_ptr_reg;
   logic [7:0]                     rdata_reg;
   logic [7:0]                     main_ctrl_reg;
   logic [7:0]                     flags_reg;
   logic [7:0]                     masks_reg;
   logic [7:0]                     speed_reg;
   logic                           int_n_reg;
   logic                           sys_rst_n_reg;
   logic                           mirror_out_reg;
   logic                           led_out_reg;
   pmsc_pkg::pmsc_state_t          state_reg;
   pmsc_pkg::pmsc_state_t          state_next;
   pmsc_pkg::pmsc_faults_t         flt;
   logic                           pr;
   logic                           pr_rise;
   logic                           mirror_group;
   logic                           supply_fault;
   logic                           illumination_fault_flag;
   logic                           fault_any;
   logic                           spi_ev;
   logic                           wr_en;
   logic [6:0]                     wr_addr;
   logic [7:0]                     wr_data;
   logic [7:0]                     flag_set;
   logic [7:0]                     flag_clr;

   // serial domain
   logic [2:0]                     bit_cnt_reg;
   logic [6:0]                     rx_shift_reg;
   logic [1:0]                     idx_reg;
   logic                           byte_end_reg;
   logic                           req_reg;
   pmsc_pkg::pmsc_spi_byte_t       hold_reg;
   logic [SYNC_STAGES-1:0]         ack_sync_reg;
   logic                           ok_reg;
   logic [7:0]                     tx_reg;

   // pins
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         pin_sync_reg <= '0;
      end else if (I_CLK_EN) begin
         pin_sync_reg[0] <= {I_POWER_REQUEST, I_FAULTS};
         for (int i = 1; i < SYNC_STAGES; i++) begin
            pin_sync_reg[i] <= pin_sync_reg[i-1];
         end
      end
   end

   assign pr  = pin_sync_reg[SYNC_STAGES-1][PW-1];
   assign flt = pin_sync_reg[SYNC_STAGES-1][PW-2:0];
   assign pr_rise = pr & ~pr_prev_reg;

   assign mirror_group = (|flt.mirror_pg) | (|flt.mirror_ov);
   assign supply_fault = mirror_group | flt.gp2_pg | flt.gp2_ov;
   assign illumination_fault_flag  = (|flt.illum_pg) | (|flt.illum_ov);
   assign fault_any    = supply_fault | illumination_fault_flag | flt.over_temp | flt.undervoltage_lockout;

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         pr_prev_reg <= 1'b0;
      end else if (I_CLK_EN) begin
         pr_prev_reg <= pr;
      end
   end

   // mode fsm
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         pmsc_pkg::PMSC_OFF: begin
            state_next = pmsc_pkg::PMSC_WAIT;
         end
         pmsc_pkg::PMSC_WAIT: begin
            if (fault_any) begin
               state_next = pmsc_pkg::PMSC_STANDBY;
            end else if (main_ctrl_reg[`PMSC_MAIN_MIRROR_BIT]) begin
               state_next = main_ctrl_reg[`PMSC_MAIN_LIGHT_BIT] ?
                            pmsc_pkg::PMSC_FULL_RUN : pmsc_pkg::PMSC_MIRROR_ONLY;
            end
         end
         pmsc_pkg::PMSC_STANDBY: begin
            if (!fault_any) begin
               state_next = pmsc_pkg::PMSC_WAIT;
            end
         end
         pmsc_pkg::PMSC_MIRROR_ONLY, pmsc_pkg::PMSC_FULL_RUN: begin
            if (fault_any) begin
               state_next = pmsc_pkg::PMSC_STANDBY;
            end else if (!main_ctrl_reg[`PMSC_MAIN_MIRROR_BIT]) begin
               state_next = pmsc_pkg::PMSC_WAIT;
            end else if (main_ctrl_reg[`PMSC_MAIN_LIGHT_BIT]) begin
               state_next = pmsc_pkg::PMSC_FULL_RUN;
            end else begin
               state_next = pmsc_pkg::PMSC_MIRROR_ONLY;
            end
         end
         default: begin
            state_next = pmsc_pkg::PMSC_OFF;
         end
      endcase
      if (!pr) begin
         state_next = pmsc_pkg::PMSC_OFF;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         state_reg      <= pmsc_pkg::PMSC_OFF;
         off_reg        <= 1'b1;
         sys_rst_n_reg  <= 1'b0;
         mirror_out_reg <= 1'b0;
         led_out_reg    <= 1'b0;
      end else if (I_CLK_EN) begin
         state_reg      <= state_next;
         off_reg        <= (state_next == pmsc_pkg::PMSC_OFF);
         sys_rst_n_reg  <= (state_next != pmsc_pkg::PMSC_OFF);
         // mirror supplies in both run levels
         // led power only in full run
         mirror_out_reg <= (state_next == pmsc_pkg::PMSC_MIRROR_ONLY) ||
                           (state_next == pmsc_pkg::PMSC_FULL_RUN);
         led_out_reg    <= (state_next == pmsc_pkg::PMSC_FULL_RUN);
      end
   end

   // serial link
   // select high holds frame logic cleared
   always_ff @(posedge I_SPI_CLK or posedge I_SPI_SS_N) begin
      if (I_SPI_SS_N) begin
         bit_cnt_reg  <= 3'h0;
         rx_shift_reg <= 7'h00;
         idx_reg      <= `PMSC_IDX_CMD;
         byte_end_reg <= 1'b0;
      end else begin
         bit_cnt_reg  <= bit_cnt_reg + 3'h1;
         rx_shift_reg <= {rx_shift_reg[5:0], I_SPI_MOSI};
         byte_end_reg <= (bit_cnt_reg == 3'h7);
         // index saturates at first data byte
         if (bit_cnt_reg == 3'h7 && idx_reg != `PMSC_IDX_DATA) begin
            idx_reg <= idx_reg + 2'h1;
         end
      end
   end

   // survives select rising so the core can still take the last byte
   always_ff @(posedge I_SPI_CLK or posedge off_reg) begin
      if (off_reg) begin
         req_reg      <= 1'b0;
         hold_reg     <= '0;
         ack_sync_reg <= '0;
         ok_reg       <= 1'b0;
      end else begin
         ack_sync_reg <= {ack_sync_reg[SYNC_STAGES-2:0], ack_reg};
         if (!I_SPI_SS_N && bit_cnt_reg == 3'h7) begin
            hold_reg.data <= {rx_shift_reg, I_SPI_MOSI};
            hold_reg.idx  <= idx_reg;
            req_reg       <= ~req_reg;
            // previous byte processed, its prefetch is stable
            ok_reg        <= (ack_sync_reg[SYNC_STAGES-1] == req_reg);
         end
      end
   end

   always_ff @(negedge I_SPI_CLK or posedge I_SPI_SS_N) begin
      if (I_SPI_SS_N) begin
         tx_reg <= 8'h00;
      end else if (byte_end_reg) begin
         // no read data during the header
         tx_reg <= (ok_reg && hold_reg.idx != `PMSC_IDX_CMD) ? rdata_reg : 8'h00;
      end else begin
         tx_reg <= {tx_reg[6:0], 1'b0};
      end
   end

   // core side
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         req_sync_reg <= '0;
         req_seen_reg <= 1'b0;
      end else if (I_CLK_EN) begin
         req_sync_reg <= {req_sync_reg[SYNC_STAGES-2:0], req_reg};
         req_seen_reg <= req_sync_reg[SYNC_STAGES-1];
      end
   end

   assign spi_ev  = (req_sync_reg[SYNC_STAGES-1] != req_seen_reg) && !off_reg;
   // write only when command asked for it
   assign wr_en   = spi_ev && cmd_write_reg && hold_reg.idx == `PMSC_IDX_DATA;
   assign wr_addr = wr_ptr_reg;
   assign wr_data = hold_reg.data;

   function automatic logic [7:0] read_reg(input logic [6:0] a);
      case (a)
         `PMSC_ADDR_MAIN_CTRL:   read_reg = main_ctrl_reg;
         `PMSC_ADDR_FAULT_FLAGS: read_reg = flags_reg;
         `PMSC_ADDR_FAULT_MASKS: read_reg = masks_reg;
         `PMSC_ADDR_SPEED_CFG:   read_reg = speed_reg;
         `PMSC_ADDR_LOW_PG:      read_reg = {flt.illum_pg, flt.gp2_pg, flt.mirror_pg};
         `PMSC_ADDR_LOW_OV:      read_reg = {1'b0, flt.illum_ov, flt.gp2_ov, flt.mirror_ov};
         `PMSC_ADDR_LOW_GROUP:   read_reg = {7'h00, mirror_group};
         `PMSC_ADDR_LOW_SUMMARY: read_reg = {6'h00, illumination_fault_flag, supply_fault};
         default:                read_reg = 8'h00;
      endcase
   endfunction

   // read data is fetched one byte ahead of where it is shifted out
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         ack_reg       <= 1'b0;
         cmd_write_reg <= 1'b0;
         rd_ptr_reg    <= 7'h00;
         wr_ptr_reg    <= 7'h00;
         rdata_reg     <= 8'h00;
      end else if (I_CLK_EN) begin
         if (off_reg) begin
            ack_reg <= 1'b0;
         end else if (spi_ev) begin
            ack_reg <= req_sync_reg[SYNC_STAGES-1];
            if (hold_reg.idx == `PMSC_IDX_CMD) begin
               cmd_write_reg <= hold_reg.data[`PMSC_CMD_WRITE_BIT];
               wr_ptr_reg    <= hold_reg.data[6:0];
               rd_ptr_reg    <= hold_reg.data[6:0] + 7'h01;
               rdata_reg     <= read_reg(hold_reg.data[6:0]);
            end else begin
               rd_ptr_reg <= rd_ptr_reg + 7'h01;
               rdata_reg  <= read_reg(rd_ptr_reg);
               if (hold_reg.idx == `PMSC_IDX_DATA) begin
                  wr_ptr_reg <= wr_ptr_reg + 7'h01;
               end
            end
         end
      end
   end

   // registers
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET || !pr) begin
         main_ctrl_reg <= `PMSC_MAIN_CTRL_RST;
      end else if (I_CLK_EN) begin
         if (wr_en && wr_addr == `PMSC_ADDR_MAIN_CTRL) begin
            main_ctrl_reg <= wr_data;
         end
         if (fault_any || pr_rise) begin
            main_ctrl_reg[`PMSC_MAIN_MIRROR_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET || !pr) begin
         masks_reg <= `PMSC_FAULT_MASKS_RST;
      end else if (I_CLK_EN && wr_en && wr_addr == `PMSC_ADDR_FAULT_MASKS) begin
         masks_reg <= wr_data;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET || !pr) begin
         speed_reg <= `PMSC_SPEED_CFG_RST;
      end else if (I_CLK_EN && wr_en && wr_addr == `PMSC_ADDR_SPEED_CFG) begin
         speed_reg <= wr_data;
      end
   end

   always_comb begin
      flag_set = 8'h00;
      flag_set[`PMSC_FLAG_SUPPLY]    = supply_fault;
      flag_set[`PMSC_FLAG_ILLUM]     = illumination_fault_flag;
      flag_set[`PMSC_FLAG_PWR_REQ]   = pr_rise;
      flag_set[`PMSC_FLAG_BAT_SHUT]  = flt.bat_shut;
      flag_set[`PMSC_FLAG_BAT_WARN]  = flt.bat_warn;
      flag_set[`PMSC_FLAG_OVER_TEMP] = flt.over_temp;
      flag_set[`PMSC_FLAG_UNDERVOLTAGE_LOCKOUT]      = flt.undervoltage_lockout;
   end

   assign flag_clr = (wr_en && wr_addr == `PMSC_ADDR_FAULT_FLAGS) ? wr_data : 8'h00;

   // write one to clear; a fault still present sets again
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET || !pr) begin
         flags_reg <= `PMSC_FAULT_FLAGS_RST;
      end else if (I_CLK_EN) begin
         flags_reg <= (flags_reg & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         int_n_reg <= 1'b1;
      end else if (I_CLK_EN) begin
         // masked flags do not pull low
         int_n_reg <= ~|(flags_reg & ~masks_reg);
      end
   end

   // outputs
   assign O_SPI_MISO         = tx_reg[7];
   assign O_SPI_MISO_OE      = ~I_SPI_SS_N & ~off_reg;
   assign O_SYS_RESET_N      = sys_rst_n_reg;
   assign O_INT_N            = int_n_reg;
   assign O_MIRROR_SUPPLY_EN = mirror_out_reg;
   assign O_LED_POWER_EN     = led_out_reg;
   assign O_SERIAL_SPEED_SEL = speed_reg[`PMSC_SPEED_SEL_BIT];

endmodule
`default_nettype wire

/* logic/pmsc_params.svh */
`ifndef PMSC_PARAMS_SVH
`define PMSC_PARAMS_SVH

// register addresses, seven-bit serial address space
`define PMSC_ADDR_MAIN_CTRL   7'h01
`define PMSC_ADDR_FAULT_FLAGS 7'h0C
`define PMSC_ADDR_FAULT_MASKS 7'h0D
`define PMSC_ADDR_SPEED_CFG   7'h17
`define PMSC_ADDR_LOW_PG      7'h27
`define PMSC_ADDR_LOW_OV      7'h28
`define PMSC_ADDR_LOW_GROUP   7'h29
`define PMSC_ADDR_LOW_SUMMARY 7'h2A

// reset values
`define PMSC_MAIN_CTRL_RST    8'h00
`define PMSC_FAULT_FLAGS_RST  8'h00
`define PMSC_FAULT_MASKS_RST  8'h00
`define PMSC_SPEED_CFG_RST    8'h00

// field positions
`define PMSC_MAIN_MIRROR_BIT  0
`define PMSC_MAIN_LIGHT_BIT   1
`define PMSC_SPEED_SEL_BIT    0
`define PMSC_CMD_WRITE_BIT    7

// fault flag bit positions
`define PMSC_FLAG_SUPPLY      0
`define PMSC_FLAG_ILLUM       1
`define PMSC_FLAG_PWR_REQ     2
`define PMSC_FLAG_BAT_SHUT    3
`define PMSC_FLAG_BAT_WARN    4
`define PMSC_FLAG_OVER_TEMP   5
`define PMSC_FLAG_UNDERVOLTAGE_LOCKOUT        6

// byte index of a transfer
`define PMSC_IDX_CMD          2'h0
`define PMSC_IDX_HDR          2'h1
`define PMSC_IDX_DATA         2'h2

`endif

/* logic/pmsc_pkg.sv */
`default_nettype none
package pmsc_pkg;

   typedef enum logic [2:0] {
      PMSC_OFF,
      PMSC_WAIT,
      PMSC_STANDBY,
      PMSC_MIRROR_ONLY,
      PMSC_FULL_RUN
   } pmsc_state_t;

   // fault monitor inputs, all active high
   typedef struct packed {
      logic [1:0] illum_ov;
      logic [1:0] illum_pg;
      logic       gp2_ov;
      logic       gp2_pg;
      logic [3:0] mirror_ov;
      logic [4:0] mirror_pg;
      logic       over_temp;
      logic       undervoltage_lockout;
      logic       bat_shut;
      logic       bat_warn;
   } pmsc_faults_t;

   // one received serial byte and its place in the transfer
   typedef struct packed {
      logic [1:0] idx;
      logic [7:0] data;
   } pmsc_spi_byte_t;

endpackage
`default_nettype wire

/* testbench/pmsc_top_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module pmsc_top_asserts (
   // core clock and control
   input wire logic                   I_CORE_CLK,
   input wire logic                   I_RESET,
   input wire logic                   I_CLK_EN,
   // power request and monitors
   input wire logic                   I_POWER_REQUEST,
   input wire pmsc_pkg::pmsc_faults_t I_FAULTS,
   // serial port
   input wire logic                   I_SPI_CLK,
   input wire logic                   I_SPI_SS_N,
   input wire logic                   I_SPI_MOSI,
   input wire logic                   O_SPI_MISO,
   input wire logic                   O_SPI_MISO_OE,
   // system outputs
   input wire logic                   O_SYS_RESET_N,
   input wire logic                   O_INT_N,
   input wire logic                   O_MIRROR_SUPPLY_EN,
   input wire logic                   O_LED_POWER_EN,
   input wire logic                   O_SERIAL_SPEED_SEL
);
   logic flt;

   // faults that force standby; battery flags only interrupt
   assign flt = I_FAULTS.over_temp | I_FAULTS.undervoltage_lockout | (|I_FAULTS.mirror_pg)
              | (|I_FAULTS.mirror_ov) | I_FAULTS.gp2_pg | I_FAULTS.gp2_ov
              | (|I_FAULTS.illum_pg) | (|I_FAULTS.illum_ov);

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RESET);

   AST_OFF_OUTPUTS: assert property (
      !O_SYS_RESET_N |-> !O_MIRROR_SUPPLY_EN && !O_LED_POWER_EN && !O_SPI_MISO_OE)
      else $error("outputs active while in off state");
   AST_REQ_LOW_OFF: assert property (
      $fell(I_POWER_REQUEST) |-> ##[1:5] !O_SYS_RESET_N)
      else $error("power request low did not reach off");
   AST_REQ_HIGH_WAIT: assert property (
      $rose(I_POWER_REQUEST) |-> ##[1:5] O_SYS_RESET_N)
      else $error("power request high did not leave off");
   AST_LED_NEEDS_MIRROR: assert property (
      O_LED_POWER_EN |-> O_MIRROR_SUPPLY_EN)
      else $error("led power without mirror supplies");
   AST_FAULT_STANDBY: assert property (
      flt [*5] |=> !O_MIRROR_SUPPLY_EN && !O_LED_POWER_EN)
      else $error("fault did not force standby");
   AST_OFF_INT_HIGH: assert property (
      !O_SYS_RESET_N [*3] |-> O_INT_N)
      else $error("interrupt low while held off");
   AST_SELECT_HIGH_FLOAT: assert property (
      I_SPI_SS_N |-> !O_SPI_MISO_OE)
      else $error("serial output driven while deselected");
   AST_SELECT_LOW_DRIVE: assert property (
      !I_SPI_SS_N && O_SYS_RESET_N |-> O_SPI_MISO_OE)
      else $error("serial output floats while selected");
   AST_RISE_MIRROR_OFF: assert property (
      $rose(O_SYS_RESET_N) |-> !O_MIRROR_SUPPLY_EN [*4])
      else $error("mirror supplies on right after power up");

   COV_FULL_RUN: cover property (O_LED_POWER_EN);
   COV_INT: cover property ($fell(O_INT_N));
   COV_SPEED: cover property ($rose(O_SERIAL_SPEED_SEL));
endmodule
`default_nettype wire

/* testbench/pmsc_spi_host.sv */
`timescale 1ns/1ns
`default_nettype none
module pmsc_spi_host (
   // serial pins toward the device
   output logic       o_sclk,
   output logic       o_ss_n,
   output logic       o_mosi,
   input  wire logic  i_miso,
   input  wire logic  i_miso_oe,
   // read results toward the bench
   output logic       o_rd_valid,
   output logic [7:0] o_rd_data
);
   // 48 ns period, inside both ranges
   localparam time HALF = 24;

   initial begin
      o_sclk = 1'b0;
      o_ss_n = 1'b1;
      o_mosi = 1'b0;
      o_rd_valid = 1'b0;
      o_rd_data = 8'h00;
   end

   // drive on falling, sample on rising
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_mosi = tx[i];
         #HALF o_sclk = 1'b1;
         rx[i] = i_miso_oe ? i_miso : 1'bx;
         #HALF o_sclk = 1'b0;
      end
   endtask

   task automatic frame(input logic [7:0] cmd, input logic [31:0] wd, input int n);
      logic [7:0] rx;
      o_ss_n = 1'b0;
      shift(cmd, rx);
      shift(8'($urandom), rx);
      for (int k = 0; k < n; k++) begin
         shift(wd[31-8*k -: 8], rx);
         if (!cmd[7]) begin
            o_rd_data = rx;
            // data settles before the strobe reaches the bench
            #1 o_rd_valid = 1'b1;
            #1 o_rd_valid = 1'b0;
         end
      end
      #HALF o_ss_n = 1'b1;
      // released line must not keep its last value
      o_mosi = ~o_mosi;
      #300;
   endtask
endmodule
`default_nettype wire

/* testbench/pmsc_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module pmsc_top_tb_top;
   logic                   clk;
   logic                   rst;
   logic                   clk_en;
   logic                   pwr_req;
   pmsc_pkg::pmsc_faults_t faults;
   logic                   sclk, ss_n, mosi, miso, miso_oe;
   logic                   sys_rst_n, int_n, mir_en, led_en, spd;
   logic                   rd_valid, snap;
   logic [7:0]             rd_data;
   logic [7:0]             exp_q[$];
   int                     n_fail, n_tests;

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   pmsc_top u_dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_CLK_EN(clk_en),
      .I_POWER_REQUEST(pwr_req), .I_FAULTS(faults), .I_SPI_CLK(sclk), .I_SPI_SS_N(ss_n),
      .I_SPI_MOSI(mosi), .O_SPI_MISO(miso), .O_SPI_MISO_OE(miso_oe),
      .O_SYS_RESET_N(sys_rst_n), .O_INT_N(int_n), .O_MIRROR_SUPPLY_EN(mir_en),
      .O_LED_POWER_EN(led_en), .O_SERIAL_SPEED_SEL(spd));

   pmsc_spi_host u_host (.o_sclk(sclk), .o_ss_n(ss_n), .o_mosi(mosi), .i_miso(miso),
      .i_miso_oe(miso_oe), .o_rd_valid(rd_valid), .o_rd_data(rd_data));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      // a note never answered is a lost result
      if (exp_q.size() != 0) n_fail++;
      if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // monitor: oldest note against each result
   always @(posedge rd_valid or posedge snap) begin
      check(snap ? {3'h0, sys_rst_n, int_n, mir_en, led_en, spd} : rd_data, exp_q.pop_front());
   end

   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host.frame({1'b0, a}, 32'h0, 1);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_host.frame({1'b1, a}, {d, 24'h0}, 1);
   endtask

   // note layout: reset_n, int_n, mirror, led, speed
   task automatic outs(input logic [7:0] e);
      repeat (6) @(posedge clk);
      exp_q.push_back(e);
      #1 snap = 1'b1;
      #1 snap = 1'b0;
   endtask

   initial begin
      #2000000;
      n_fail++;
      end_of_test();
   end

   initial begin
      logic [7:0]             mask, flag;
      pmsc_pkg::pmsc_faults_t f;
      rst = 1'b1; clk_en = 1'b1; pwr_req = 1'b0; faults = '0; snap = 1'b0;
      n_fail = 0; n_tests = 0;
      void'($urandom(32'hECBC92B4));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      outs(8'h08);
      wr(7'h01, 8'h03);
      outs(8'h08);
      @(posedge clk) pwr_req <= 1'b1;
      outs(8'h10);
      rd(7'h01, 8'h00);
      rd(7'h0C, 8'h04);
      wr(7'h0C, 8'h04);
      outs(8'h18);
      wr(7'h01, 8'h01); outs(8'h1C);
      rd(7'h01, 8'h01);
      wr(7'h01, 8'h03); outs(8'h1E);
      wr(7'h01, 8'h00); outs(8'h18);
      mask = 8'($urandom) & 8'h7F;
      wr(7'h0D, mask); rd(7'h0D, mask);
      @(posedge clk) faults.bat_warn <= 1'b1;
      outs({4'h1, mask[4], 3'h0});
      rd(7'h0C, 8'h10);
      @(posedge clk) faults.bat_warn <= 1'b0;
      wr(7'h0C, 8'h10); wr(7'h0D, 8'h00);
      outs(8'h18);
      for (int i = 0; i < 5; i++) begin
         f = '0;
         case (i)
            0: f.mirror_pg[2] = 1'b1;
            1: f.gp2_ov = 1'b1;
            2: f.illum_ov[1] = 1'b1;
            3: f.over_temp = 1'b1;
            default: f.undervoltage_lockout = 1'b1;
         endcase
         flag = (i < 2) ? 8'h01 : (i == 2) ? 8'h02 : (i == 3) ? 8'h20 : 8'h40;
         wr(7'h01, 8'h03); outs(8'h1E);
         @(posedge clk) faults <= f;
         outs(8'h10);
         rd(7'h0C, flag);
         rd(7'h27, {f.illum_pg, f.gp2_pg, f.mirror_pg});
         rd(7'h28, {1'b0, f.illum_ov, f.gp2_ov, f.mirror_ov});
         rd(7'h29, {7'h0, |{f.mirror_pg, f.mirror_ov}});
         rd(7'h2A, (i < 3) ? flag : 8'h00);
         rd(7'h01, 8'h02);
         @(posedge clk) faults <= '0;
         outs(8'h10);
         wr(7'h0C, 8'hFF);
         outs(8'h18);
      end
      // wrap: 0x7F, 0x00, then 0x01
      u_host.frame(8'hFF, 32'h1122_0300, 3);
      outs(8'h1E);
      exp_q.push_back(8'h00);
      exp_q.push_back(8'h03);
      u_host.frame(8'h00, 32'h0, 2);
      rd(7'h7F, 8'h00);
      wr(7'h17, 8'h01); outs(8'h1F);
      // frozen core must not see a short fault
      @(posedge clk) begin
         clk_en <= 1'b0;
         faults.bat_warn <= 1'b1;
      end
      outs(8'h1F);
      @(posedge clk) begin
         clk_en <= 1'b1;
         faults <= '0;
      end
      outs(8'h1F);
      rd(7'h0C, 8'h00);
      rd(7'h17, 8'h01);
      wr(7'h2A, 8'hFF); rd(7'h2A, 8'h00);
      // host lowers request for lowest power
      @(posedge clk) pwr_req <= 1'b0;
      outs(8'h08);
      end_of_test();
   end
endmodule

bind pmsc_top pmsc_top_asserts u_asserts (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET),
   .I_CLK_EN(I_CLK_EN), .I_POWER_REQUEST(I_POWER_REQUEST), .I_FAULTS(I_FAULTS),
   .I_SPI_CLK(I_SPI_CLK), .I_SPI_SS_N(I_SPI_SS_N), .I_SPI_MOSI(I_SPI_MOSI),
   .O_SPI_MISO(O_SPI_MISO), .O_SPI_MISO_OE(O_SPI_MISO_OE), .O_SYS_RESET_N(O_SYS_RESET_N),
   .O_INT_N(O_INT_N), .O_MIRROR_SUPPLY_EN(O_MIRROR_SUPPLY_EN),
   .O_LED_POWER_EN(O_LED_POWER_EN), .O_SERIAL_SPEED_SEL(O_SERIAL_SPEED_SEL));
`default_nettype wire
